/* hw/lf_half_bit_sampler.sv */
// Per-channel half-bit sampler: one sample every 12 oscillator ticks.
// Assumes osc_tick is a one-cycle pulse at the crystal rate.
module lf_half_bit_sampler
   import lf_wake_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic osc_tick, // Crystal tick pulse
   input wire logic data_in, // Sliced data
   output logic hb_strobe, // Half-bit sample pulse
   output logic hb_value // Sampled level
);
   logic [3:0] div_reg, div_next;
   logic strobe_reg, strobe_next;
   logic val_reg, val_next;

   always_comb begin
      div_next = div_reg;
      strobe_next = 1'b0;
      val_next = val_reg;
      if (osc_tick) begin
         if (div_reg == 4'(OSC_PER_HALFBIT - 1)) begin
            div_next = 4'h0;
            strobe_next = 1'b1;
            val_next = data_in;
         end else begin
            div_next = div_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 4'h0;
         strobe_reg <= 1'b0;
         val_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         strobe_reg <= strobe_next;
         val_reg <= val_next;
      end
   end

   assign hb_strobe = strobe_reg;
   assign hb_value = val_reg;
endmodule

/* hw/lf_pattern_correlator.sv */
// One channel's correlator: 16 half-bit window against the wake pattern.
// Assumes hb_strobe pulses once per half-bit while the channel runs.
module lf_pattern_correlator
   import lf_wake_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic clear, // Synchronous correlator reset
   input wire logic enable, // Channel enabled
   input wire logic hb_strobe, // Half-bit pulse
   input wire logic hb_value, // Half-bit value
   input wire logic [1:0] tolerance, // Allowed zero errors
   output logic match, // Pattern seen, one pulse
   output logic running // Correlator not stopped
);
   logic [15:0] win_reg, win_next;
   logic [4:0] fill_reg, fill_next;
   logic [5:0] idle_reg, idle_next;
   logic match_reg, match_next;
   logic [15:0] shifted;
   logic [4:0] zero_err;

   function automatic logic [4:0] count_ones(input logic [15:0] v);
      logic [4:0] n;
      n = 5'h0;
      for (int i = 0; i < 16; i++) n = n + 5'(v[i]);
      return n;
   endfunction

   always_comb begin
      shifted = {win_reg[14:0], hb_value};
      zero_err = count_ones(shifted & ~WAKE_PATTERN);
      win_next = win_reg;
      fill_next = fill_reg;
      idle_next = idle_reg;
      match_next = 1'b0;
      if (clear || !enable) begin
         win_next = 16'h0;
         fill_next = 5'h0;
         idle_next = 6'h0;
      end else if (hb_strobe) begin
         if (hb_value) idle_next = 6'h0;
         else if (idle_reg != 6'(IDLE_HALFBITS)) idle_next = idle_reg + 6'h1;
         if (idle_reg == 6'(IDLE_HALFBITS) && !hb_value) begin
            fill_next = 5'h0;
         end else begin
            win_next = shifted;
            if (fill_reg != 5'(PATTERN_LEN)) fill_next = fill_reg + 5'h1;
            // All ones must be present, some zeros may be wrong
            if ((fill_reg >= 5'(PATTERN_LEN - 1)) &&
                ((shifted & WAKE_PATTERN) == WAKE_PATTERN) &&
                (zero_err <= 5'(tolerance))) begin
               match_next = 1'b1;
               fill_next = 5'h0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_reg <= 16'h0;
         fill_reg <= 5'h0;
         idle_reg <= 6'h0;
         match_reg <= 1'b0;
      end else begin
         win_reg <= win_next;
         fill_reg <= fill_next;
         idle_reg <= idle_next;
         match_reg <= match_next;
      end
   end

   assign match = match_reg;
   assign running = (idle_reg != 6'(IDLE_HALFBITS));
endmodule

/* hw/lf_wake_pkg.sv */
// Constants, register map and types for the LF wakeup correlator.
// Assumes a 200 MHz APB clock; the oscillator tick is derived from it.
package lf_wake_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] ANALOG_OFF = 8'h04;
   localparam logic [7:0] WAKECLR_OFF = 8'h08;
   localparam logic [7:0] STATUS_OFF = 8'h0c;
   localparam logic [7:0] HALFBIT_OFF = 8'h10;
   // Control register fields
   localparam int CTRL_CH_EN_LSB = 0;
   localparam int CTRL_DOUBLE_BIT = 3;
   localparam int CTRL_TOL_LSB = 4;
   localparam int CTRL_CORR_RST_BIT = 6;
   // Analog register fields
   localparam int AN_ROT_LSB = 0;
   localparam int AN_ATT_LSB = 2;
   localparam int AN_SLOPE_BIT = 5;
   localparam int AN_REG_EN_BIT = 6;
   // Reset values
   localparam logic [6:0] CTRL_RESET = 7'h07;
   localparam logic [6:0] ANALOG_RESET = 7'h40;
   // Rotator code that shorts the inputs
   localparam logic [1:0] ROT_SHORT = 2'h3;
   // Timing
   localparam int PCLK_HZ = 200_000_000;
   localparam int XTAL_HZ = 32_768;
   localparam int XTAL_TICK_CYC = PCLK_HZ / XTAL_HZ;
   localparam int OSC_PER_HALFBIT = 12;
   localparam int HALFBITS_PER_BIT = 2;
   localparam int PATTERN_LEN = 16;
   // Manchester 0x96, one sent high then low, MSB first
   localparam logic [15:0] WAKE_PATTERN = 16'h9669;
   localparam int IDLE_HALFBITS = 32;
   localparam int ARTIFICIAL_HOURS = 2;
   localparam longint ARTIFICIAL_TICKS =
      longint'(ARTIFICIAL_HOURS) * 3600 * XTAL_HZ;
   localparam int POR_TICKS = 8;
   localparam int NCH = 3;
   typedef enum logic [1:0] {ST_POR, ST_RUN} por_state_t;
endpackage

/* hw/lf_wakeup_pattern_correlator.sv */
// Top of the LF wakeup logic: APB registers, three correlators, wake pin.
// Assumes sliced detector data synchronous to pclk and an APB master.
//
// Decided for this implementation: the APB register port and the address map.
module lf_wakeup_pattern_correlator
   import lf_wake_pkg::*;
#(
   parameter longint ARTIFICIAL_PERIOD = ARTIFICIAL_TICKS,
   parameter int TICK_CYCLES = XTAL_TICK_CYC
)
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic [2:0] slice_data, // Sliced data per channel
   output logic wake_n, // Wake output, low active
   output logic [1:0] rotator_sel, // Antenna rotator mode
   output logic [2:0] atten_en, // Input attenuation per channel
   output logic inputs_short, // Differential inputs shorted
   output logic slope_high, // High slope amplifier
   output logic [2:0] chan_en, // Channel power enable
   output logic reg_en // Regulator enable
);
   logic [6:0] ctrl_reg, ctrl_next;
   logic [6:0] analog_reg, analog_next;
   logic clr_bit_reg, clr_bit_next; // wake_clear_bit
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [15:0] tick_div_reg, tick_div_next;
   logic tick_reg, tick_next;
   logic [37:0] art_reg, art_next;
   logic [3:0] por_cnt_reg, por_cnt_next;
   por_state_t por_reg, por_next;
   logic wake_reg, wake_next;
   logic first_reg, first_next;
   logic [5:0] gap_reg, gap_next;
   logic [2:0] rotator_reg_q;
   logic [2:0] outs_dummy;
   logic [2:0] ch_strobe, ch_value, ch_match, ch_run;
   logic any_strobe, any_match, clear_toggle, art_fire;
   logic access, wr, rd;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   assign access = psel && penable && !pready_reg;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;

   // Crystal tick derived from pclk
   always_comb begin
      tick_next = 1'b0;
      tick_div_next = tick_div_reg + 16'h1;
      if (tick_div_reg == 16'(TICK_CYCLES - 1)) begin
         tick_div_next = 16'h0;
         tick_next = 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gen_ch
         lf_half_bit_sampler u_samp (
            .pclk(pclk),
            .presetn(presetn),
            .osc_tick(tick_reg),
            .data_in(slice_data[g]),
            .hb_strobe(ch_strobe[g]),
            .hb_value(ch_value[g])
         );
         lf_pattern_correlator u_corr (
            .pclk(pclk),
            .presetn(presetn),
            .clear(ctrl_reg[CTRL_CORR_RST_BIT]),
            .enable(ctrl_reg[CTRL_CH_EN_LSB + g] && por_reg == ST_RUN),
            .hb_strobe(ch_strobe[g]),
            .hb_value(ch_value[g]),
            .tolerance(ctrl_reg[CTRL_TOL_LSB +: 2]),
            .match(ch_match[g]),
            .running(ch_run[g])
         );
      end
   endgenerate

   assign any_strobe = |ch_strobe;
   assign any_match = |ch_match;

   // Register file
   always_comb begin
      ctrl_next = ctrl_reg;
      analog_next = analog_reg;
      clr_bit_next = clr_bit_reg;
      prdata_next = prdata_reg;
      pready_next = access;
      pslverr_next = 1'b0;
      // Self-clearing correlator reset
      ctrl_next[CTRL_CORR_RST_BIT] = 1'b0;
      if (wr) begin
         if (addr_hit(paddr, CTRL_OFF)) ctrl_next = pwdata[6:0];
         else if (addr_hit(paddr, ANALOG_OFF)) analog_next = pwdata[6:0];
         else if (addr_hit(paddr, WAKECLR_OFF)) clr_bit_next = pwdata[0];
         else pslverr_next = 1'b1;
      end
      if (rd) begin
         prdata_next = 32'h0;
         if (addr_hit(paddr, CTRL_OFF)) prdata_next[6:0] = ctrl_reg;
         else if (addr_hit(paddr, ANALOG_OFF)) prdata_next[6:0] = analog_reg;
         else if (addr_hit(paddr, WAKECLR_OFF)) prdata_next[0] = clr_bit_reg;
         else if (addr_hit(paddr, STATUS_OFF))
            prdata_next[5:0] = {ch_run, ~wake_reg, first_reg,
                                por_reg == ST_RUN};
         else if (addr_hit(paddr, HALFBIT_OFF))
            prdata_next[2:0] = ch_value;
         else pslverr_next = 1'b1;
      end
   end

   // Any edge of the clear bit releases wake
   assign clear_toggle = clr_bit_next != clr_bit_reg;
   assign art_fire = art_reg == 38'(ARTIFICIAL_PERIOD - 1);

   // Wake, power-on and artificial counter
   always_comb begin
      por_next = por_reg;
      por_cnt_next = por_cnt_reg;
      wake_next = wake_reg;
      first_next = first_reg;
      gap_next = gap_reg;
      art_next = art_fire ? 38'h0 : art_reg + 38'(tick_reg);
      unique case (por_reg)
         ST_POR: begin
            wake_next = 1'b0;
            if (tick_reg) por_cnt_next = por_cnt_reg + 4'h1;
            if (por_cnt_reg == 4'(POR_TICKS)) begin
               por_next = ST_RUN;
               wake_next = 1'b1;
            end
         end
         ST_RUN: begin
            if (first_reg && any_strobe) gap_next = gap_reg + 6'h1;
            if (gap_reg > 6'(PATTERN_LEN)) begin
               first_next = 1'b0;
               gap_next = 6'h0;
            end
            // Clear first, so a wake event in the same cycle wins
            if (clear_toggle) wake_next = 1'b0;
            if (any_match) begin
               if (!ctrl_reg[CTRL_DOUBLE_BIT]) begin
                  wake_next = 1'b1;
               end else if (first_reg && gap_reg >= 6'(PATTERN_LEN - 1)) begin
                  wake_next = 1'b1;
                  first_next = 1'b0;
               end else begin
                  first_next = 1'b1;
                  gap_next = 6'h0;
               end
            end
            if (ctrl_reg[CTRL_CORR_RST_BIT]) first_next = 1'b0;
            if (art_fire) wake_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
         analog_reg <= ANALOG_RESET;
         clr_bit_reg <= 1'b0;
         prdata_reg <= 32'h0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         tick_div_reg <= 16'h0;
         tick_reg <= 1'b0;
         art_reg <= 38'h0;
         por_cnt_reg <= 4'h0;
         por_reg <= ST_POR;
         wake_reg <= 1'b0;
         first_reg <= 1'b0;
         gap_reg <= 6'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         analog_reg <= analog_next;
         clr_bit_reg <= clr_bit_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         tick_div_reg <= tick_div_next;
         tick_reg <= tick_next;
         art_reg <= art_next;
         por_cnt_reg <= por_cnt_next;
         por_reg <= por_next;
         wake_reg <= wake_next;
         first_reg <= first_next;
         gap_reg <= gap_next;
      end
   end

   // Pin drive registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_n <= 1'b1;
         rotator_sel <= 2'h0;
         atten_en <= 3'h0;
         inputs_short <= 1'b0;
         slope_high <= 1'b0;
         chan_en <= 3'h7;
         reg_en <= 1'b1;
      end else begin
         wake_n <= ~wake_reg;
         rotator_sel <= analog_reg[AN_ROT_LSB +: 2];
         atten_en <= analog_reg[AN_ATT_LSB +: 3];
         inputs_short <= analog_reg[AN_ROT_LSB +: 2] == ROT_SHORT;
         slope_high <= analog_reg[AN_SLOPE_BIT];
         chan_en <= ctrl_reg[CTRL_CH_EN_LSB +: 3];
         reg_en <= analog_reg[AN_REG_EN_BIT];
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
endmodule

/* verif/lf_wake_assertions.sv */
// Checker for the LF wakeup block: APB handshake, wake pin, controls.
// Bound to the top module below; sees its ports only.
module lf_wake_assertions
   import lf_wake_pkg::*;
#(
   parameter int TICK_CYCLES = XTAL_TICK_CYC
)
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB write
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic wake_n, // Wake pin
   input wire logic [1:0] rotator_sel, // Rotator
   input wire logic [2:0] atten_en, // Attenuation
   input wire logic inputs_short, // Inputs shorted
   input wire logic slope_high, // Slope
   input wire logic [2:0] chan_en, // Channel enables
   input wire logic reg_en // Regulator
);
   localparam int POR_MIN = (POR_TICKS - 1) * TICK_CYCLES;
   localparam int POR_MAX = (POR_TICKS + 1) * TICK_CYCLES + 3;
   logic [15:0] por_reg, por_next;
   logic [31:0] wd_reg, wd_next;
   logic clr_reg, clr_next, done, mapped;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign done = psel && penable && pready && pwrite;
   assign mapped = pwrite ?
      paddr inside {CTRL_OFF, ANALOG_OFF, WAKECLR_OFF} :
      paddr inside {CTRL_OFF, ANALOG_OFF, WAKECLR_OFF, STATUS_OFF,
      HALFBIT_OFF};
   always_comb begin
      por_next = (por_reg <= 16'(POR_MAX)) ? por_reg + 16'h1 : por_reg;
      wd_next = pwdata;
      clr_next = (done && paddr == WAKECLR_OFF) ? pwdata[0] : clr_reg;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_reg <= 16'h0;
         wd_reg <= 32'h0;
         clr_reg <= 1'b0;
      end else begin
         por_reg <= por_next;
         wd_reg <= wd_next;
         clr_reg <= clr_next;
      end
   end
   chk_ready_after_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held");
   chk_error_unmapped: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr wrong");
   chk_short_rotator: assert property (
      inputs_short == (rotator_sel == ROT_SHORT)) else $error("short wrong");
   chk_analog_apply: assert property (
      done && paddr == ANALOG_OFF |=> rotator_sel == wd_reg[1:0] &&
      atten_en == wd_reg[4:2] && slope_high == wd_reg[5])
      else $error("analog controls wrong");
   chk_wake_clear: assert property (
      done && paddr == WAKECLR_OFF && pwdata[0] != clr_reg |-> ##[1:2] wake_n)
      else $error("wake not cleared");
   chk_wake_held: assert property (
      !wake_n && !psel && !$past(psel) && !$past(psel, 2) |=> !wake_n)
      else $error("wake released");
   chk_reset_defaults: assert property (
      $rose(presetn) |-> chan_en == 3'h7 && reg_en && rotator_sel == 2'h0
      && atten_en == 3'h0 && !slope_high) else $error("defaults wrong");
   chk_por_high: assert property (por_reg < 16'(POR_MIN) |-> wake_n)
      else $error("wake low too early");
   chk_por_low: assert property (por_reg == 16'(POR_MAX) |-> !wake_n)
      else $error("power-on wake missing");
endmodule

bind lf_wakeup_pattern_correlator lf_wake_assertions #(
   .TICK_CYCLES(TICK_CYCLES)
) i_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .wake_n(wake_n), .rotator_sel(rotator_sel),
   .atten_en(atten_en), .inputs_short(inputs_short),
   .slope_high(slope_high), .chan_en(chan_en), .reg_en(reg_en));

/* verif/lf_wake_mcu.sv */
// Controller model: watches the wake pin and counts wakeups.
// Assumes wake_n is a level synchronous to pclk.
module lf_wake_mcu
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, low
   input wire logic wake_n, // Wake pin
   output int wake_count // Wakeups seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b1;
         wake_count <= 0;
      end else begin
         prev <= wake_n;
         if (prev && !wake_n) wake_count <= wake_count + 1;
      end
   end
endmodule

/* verif/tb.sv */
// Testbench for the LF wakeup block: APB master, sliced data, wake pin.
// Assumes the checker is bound and the controller model counts wakes.
module tb;
   import lf_wake_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   localparam int HB = OSC_PER_HALFBIT * TICK;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, wake_n;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, pwd;
   logic [2:0] slice_data, atten_en, chan_en;
   logic [1:0] rotator_sel;
   logic inputs_short, slope_high, reg_en, er, clr_bit;
   logic [15:0] pat;
   int num_errors, n_compared, seed, wake_count, exp_wakes, ch, i;
   logic [1:0] tol[6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h3, 2'h2};
   logic [15:0] flip[6] = '{16'h0, 16'h4000, 16'h4000, 16'h4102, 16'h0200,
      16'h6002};
   logic hit[6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};
   lf_wakeup_pattern_correlator #(.ARTIFICIAL_PERIOD(8000),
      .TICK_CYCLES(TICK)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .slice_data(slice_data),
      .wake_n(wake_n), .rotator_sel(rotator_sel), .atten_en(atten_en),
      .inputs_short(inputs_short), .slope_high(slope_high),
      .chan_en(chan_en), .reg_en(reg_en));
   lf_wake_mcu i_mcu (.pclk(pclk), .presetn(presetn), .wake_n(wake_n),
      .wake_count(wake_count));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic check(input string name, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results;
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [15:0] manch(input logic [7:0] b);
      logic [15:0] r;
      r = 16'h0;
      for (int j = 7; j >= 0; j--) r = {r[13:0], b[j] ? 2'h2 : 2'h1};
      return r;
   endfunction
   function automatic logic [31:0] ctrl_val(input logic [1:0] t,
      input logic d, r);
      return 32'h7 | (32'(d) << CTRL_DOUBLE_BIT) | (32'(t) << CTRL_TOL_LSB)
         | (32'(r) << CTRL_CORR_RST_BIT);
   endfunction
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         // Settled value, as the next rising edge will sample it
         @(negedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
         num_errors++;
         results();
      end
   endtask
   task automatic send(input logic [15:0] hb, input int n,
      input logic [2:0] m);
      for (int j = n - 1; j >= 0; j--) begin
         slice_data <= hb[j] ? m : 3'h0;
         repeat (HB) @(posedge pclk);
      end
   endtask
   task automatic wait_low(input int bound);
      int k;
      for (k = 0; k < bound && wake_n !== 1'b0; k++) @(posedge pclk);
      if (k == bound) begin
         num_errors++;
         results();
      end
   endtask
   task automatic clear_wake;
      clr_bit = !clr_bit;
      apb(1'b1, WAKECLR_OFF, {31'h0, clr_bit});
      repeat (3) @(posedge pclk);
      check("wake_n", wake_n, 32'h1);
   endtask
   initial begin
      seed = 32'h4554dabe;
      {psel, penable, pwrite, paddr, pwdata, slice_data, clr_bit} = '0;
      presetn = 1'b0;
      pat = manch(8'h96);
      repeat (12) @(posedge pclk);
      check("wake_n", wake_n, 32'h1);
      check("controls", {rotator_sel, atten_en, inputs_short, slope_high,
         chan_en, reg_en}, 32'hf);
      presetn <= 1'b1;
      wait_low(200);
      check("wake_n", wake_n, 32'h0);
      exp_wakes = 1;
      repeat (10) @(posedge pclk);
      apb(1'b0, CTRL_OFF, 32'h0);
      check("ctrl", rd, 32'h7);
      apb(1'b0, ANALOG_OFF, 32'h0);
      check("analog", rd, 32'h40);
      apb(1'b0, 8'h14, 32'h0);
      check("pslverr", {31'h0, er}, 32'h1);
      clear_wake();
      for (i = 0; i < 4; i++) begin
         pwd = ($random(seed) & 32'h7c) | 32'(i);
         apb(1'b1, ANALOG_OFF, pwd);
         repeat (2) @(posedge pclk);
         check("rotator", rotator_sel, pwd[1:0]);
         check("atten", atten_en, pwd[4:2]);
         check("short", inputs_short, i == 3);
         check("slope", slope_high, pwd[5]);
         apb(1'b0, ANALOG_OFF, 32'h0);
         check("analog", rd, pwd);
      end
      for (i = 0; i < 6; i++) begin
         ch = {$random(seed)} % 3;
         apb(1'b1, CTRL_OFF, ctrl_val(tol[i], 1'b0, 1'b0));
         send(16'haa, 8, 3'h7);
         send(pat ^ flip[i], 16, 3'h1 << ch);
         send(16'h0, 2, 3'h0);
         check("wake_n", wake_n, {31'h0, !hit[i]});
         if (hit[i]) begin
            exp_wakes++;
            clear_wake();
         end
      end
      apb(1'b1, CTRL_OFF, ctrl_val(2'h0, 1'b1, 1'b0));
      send(16'haa, 8, 3'h7);
      send(pat, 16, 3'h1 << ch);
      send(16'h0, 2, 3'h0);
      check("wake_n", wake_n, 32'h1);
      send(16'haa, 8, 3'h7);
      send(pat, 16, 3'h1 << ch);
      send(pat, 16, 3'h1 << ((ch + 1) % 3));
      send(16'h0, 2, 3'h0);
      check("wake_n", wake_n, 32'h0);
      exp_wakes++;
      clear_wake();
      send(16'haa, 8, 3'h7);
      send(pat, 16, 3'h7);
      send(16'h0, 4, 3'h0);
      send(pat, 16, 3'h7);
      send(16'h0, 2, 3'h0);
      check("wake_n", wake_n, 32'h1);
      apb(1'b1, CTRL_OFF, ctrl_val(2'h0, 1'b0, 1'b0));
      send(16'haa, 8, 3'h7);
      fork
         send(pat >> 1, 15, 3'h1);
         begin
            repeat (14 * HB) @(posedge pclk);
            apb(1'b1, CTRL_OFF, ctrl_val(2'h0, 1'b0, 1'b1));
         end
      join
      send(pat, 1, 3'h1);
      send(16'h0, 2, 3'h0);
      check("wake_n", wake_n, 32'h1);
      send(16'h0, 40, 3'h0);
      apb(1'b0, STATUS_OFF, 32'h0);
      check("running", rd[5:3], 32'h0);
      send(16'haa, 8, 3'h7);
      apb(1'b0, STATUS_OFF, 32'h0);
      check("running", rd[5:3], 32'h7);
      wait_low(40000);
      check("wake_n", wake_n, 32'h0);
      exp_wakes++;
      clear_wake();
      check("wakeups", wake_count, exp_wakes);
      results();
   end
endmodule
